// file: rtl/lcg_pkg.sv
// shared constants and types for the logic cell group
package lcg_pkg;
	localparam int LCG_SLICES = 4;
	localparam int LCG_LUTS = 8;
	localparam int LCG_LUT_BITS = 16;
	localparam int LCG_LUT_AW = 4;
	localparam int LCG_RAM_AW = 7;
	localparam int LCG_DP_AW = 6;
	localparam int LCG_DP_BASE = 4;
	localparam logic [15:0] LCG_LUT_RST = 16'h0000;
	localparam logic LCG_INIT_PEND_RST = 1'b1;
	localparam logic LCG_Q_RST = 1'b0;
	localparam logic LCG_CLK_PREV_RST = 1'b0;

	// set/reset configuration of one slice
	typedef enum logic [6:0] {
		LCG_SETRST_NONE = 7'h01,
		LCG_SYNC_SET = 7'h02,
		LCG_SYNC_RST = 7'h04,
		LCG_SYNC_BOTH = 7'h08,
		LCG_ASYNC_PRE = 7'h10,
		LCG_ASYNC_CLR = 7'h20,
		LCG_ASYNC_BOTH = 7'h40
	} lcg_setrst_t;

	// what the look-up tables of the group do
	typedef enum logic [2:0] {
		LCG_FN_LOGIC = 3'h1,
		LCG_FN_RAM = 3'h2,
		LCG_FN_SHIFT = 3'h4
	} lcg_func_t;

	// distributed ram organisation
	typedef enum logic [6:0] {
		LCG_SP16X8 = 7'h01,
		LCG_SP32X4 = 7'h02,
		LCG_SP64X2 = 7'h04,
		LCG_SP128X1 = 7'h08,
		LCG_DP16X4 = 7'h10,
		LCG_DP32X2 = 7'h20,
		LCG_DP64X1 = 7'h40
	} lcg_ramorg_t;
endpackage

// file: rtl/lcg_store.sv
// the two storage elements of one slice
`timescale 1ns/1ns
module lcg_store import lcg_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_load,
	input wire logic i_clk_edge,
	input wire logic i_clk_level,
	input wire logic i_ce,
	input wire logic i_set_reset,
	input wire logic i_opposite_force,
	input wire logic i_latch,
	input wire lcg_setrst_t i_mode,
	input wire logic [1:0] i_force_one_attr,
	input wire logic [1:0] i_init_indep,
	input wire logic [1:0] i_power_up_one,
	input wire logic [1:0] i_d,
	output logic [1:0] o_q
);
	logic [1:0] q;
	logic [1:0] next_q;
	logic [1:0] set_req;
	logic [1:0] rst_req;
	logic [1:0] do_rst;
	logic [1:0] do_set;
	logic [1:0] pu_val;
	logic allow_set;
	logic allow_rst;
	logic is_async;
	logic ctrl_time;
	logic capture;

	assign allow_set = (i_mode == LCG_SYNC_SET) | (i_mode == LCG_SYNC_BOTH)
		| (i_mode == LCG_ASYNC_PRE) | (i_mode == LCG_ASYNC_BOTH);
	assign allow_rst = (i_mode == LCG_SYNC_RST) | (i_mode == LCG_SYNC_BOTH)
		| (i_mode == LCG_ASYNC_CLR) | (i_mode == LCG_ASYNC_BOTH);
	assign is_async = (i_mode == LCG_ASYNC_PRE) | (i_mode == LCG_ASYNC_CLR) | (i_mode == LCG_ASYNC_BOTH);
	// edge for a flip-flop, active level for a latch
	assign ctrl_time = i_latch ? i_clk_level : i_clk_edge;
	assign capture = ctrl_time & i_ce;

	assign set_req = ({2{i_set_reset}} & i_force_one_attr) | ({2{i_opposite_force}} & ~i_force_one_attr);
	assign rst_req = ({2{i_set_reset}} & ~i_force_one_attr) | ({2{i_opposite_force}} & i_force_one_attr);
	assign do_rst = {2{allow_rst}} & rst_req;
	assign do_set = {2{allow_set}} & set_req & ~do_rst;
	assign pu_val = (i_init_indep & i_power_up_one) | (~i_init_indep & i_force_one_attr);

	always_comb begin
		for (int e = 0; e < 2; e++) begin
			if (i_load) begin
				next_q[e] = pu_val[e];
			end else if ((do_rst[e] | do_set[e]) & (is_async | ctrl_time)) begin
				next_q[e] = do_set[e];
			end else if (capture) begin
				next_q[e] = i_d[e];
			end else begin
				next_q[e] = q[e];
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			q <= {2{LCG_Q_RST}};
		end else begin
			q <= next_q;
		end
	end

	// asynchronous forcing shows at once, without waiting for a clock
	assign o_q = is_async ? ((q & ~(do_rst | do_set)) | do_set) : q;
endmodule

// file: rtl/lcg_cell_group.sv
// one logic cell group: four slices of tables, storage, combiners, carry and bus logic
//
// Notes on behaviour
// - each storage element is configured as edge flip-flop or level latch
// - clock enable active high by default; unused enable acts as always asserted
// - set/reset input forces one or zero as the force attribute says
// - opposite-force input drives the complement; reset wins when both act
// - power-up value follows force choice unless configured independently
// - per slice set/reset: none, sync set/reset/both, async preset/clear/both
// - sync reset beats sync set; async clear beats async preset
// - clock, enable, set/reset shared per slice, each with own polarity
// - each table is a 16x1 ram, clocked write, combinational read
// - group ram: single-port 16x8..128x1, dual-port 16x4..64x1
// - ram write enable is slice set/reset, active high, slice clock shared
// - dual-port: write plus read port, and separate read-only address port
// - single-port shares one address; second table writes at port one address
// - tables act as rom, cascadable 16x1 to 256x1, loaded at configuration
// - each table shifts 16 bits on clock with enable, tap read by address
// - shift tables have no set or reset; flip-flop gives synchronous tap
// - last bit of one shift table feeds first of next, 128 per group
// - combiners give 4:1 per slice up to 32:1 over two groups
// - two upward carry chains, two bits per slice, also cascade wide logic
// - per slice xor for 2-bit adder and and gate for multiplier products
// - or chain joins previous row output with slice top carry mux output
// - two bus drivers with own input and enable, built as and-or logic
`timescale 1ns/1ns
module lcg_cell_group import lcg_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ginit,
	input wire lcg_func_t i_func,
	input wire lcg_ramorg_t i_ram_org,
	input wire logic [7:0][15:0] i_lut_init,
	input wire logic [7:0][3:0] i_lut_addr,
	input wire logic [3:0] i_slice_clk,
	input wire logic [3:0] i_slice_ce,
	input wire logic [3:0] i_ce_used,
	input wire logic [3:0] i_clk_inv,
	input wire logic [3:0] i_ce_inv,
	input wire logic [3:0] i_set_reset_inv,
	input wire logic [3:0] i_opposite_force_inv,
	input wire logic [3:0] i_set_reset_input,
	input wire logic [3:0] i_bypass_x_input,
	input wire logic [3:0] i_opposite_force_input,
	input wire logic [3:0] i_latch_mode,
	input wire lcg_setrst_t [3:0] i_setrst_mode,
	input wire logic [7:0] i_force_one_attr,
	input wire logic [7:0] i_init_indep,
	input wire logic [7:0] i_power_up_one,
	input wire logic [7:0] i_lut_x_to_d,
	input wire logic [7:0] i_xor_sel,
	input wire logic [7:0] i_di_sel,
	input wire logic [6:0] i_ram_addr,
	input wire logic [7:0] i_ram_din,
	input wire logic [5:0] i_dp_raddr,
	input wire logic i_shift_in,
	input wire logic [1:0] i_carry_in,
	input wire logic [1:0] i_sop_in,
	input wire logic i_f8_neighbor,
	input wire logic [1:0] i_bus_in,
	input wire logic [1:0] i_bus_oe,
	input wire logic [1:0] i_hline_in,
	output logic [7:0] o_x,
	output logic [7:0] o_q,
	output logic [3:0] o_five_input_combiner,
	output logic [3:0] o_wide_combiner,
	output logic o_f7,
	output logic [1:0] o_carry_out,
	output logic [1:0] o_sop_out,
	output logic o_shift_out,
	output logic [7:0] o_ram_dout,
	output logic [3:0] o_dp_dout,
	output logic [1:0] o_hline_out
);
	logic [15:0] lut_mem [LCG_LUTS];
	logic init_pend;
	logic cfg_load;
	logic [3:0] clk_prev;
	logic [3:0] clk_level;
	logic [3:0] clk_edge;
	logic [3:0] ce_eff;
	logic [3:0] setrst_eff;
	logic [3:0] opp_eff;
	logic [7:0] lut_out;
	logic [7:0] shift_feed;
	logic [7:0] ram_we;
	logic [7:0] ram_bit_in;
	logic [7:0] byp;
	logic [7:0] multiplier_and_gate;
	logic [7:0] carry_di;
	logic [7:0] carry_ci;
	logic [7:0] carry_select_mux;
	logic [7:0] sum;
	logic [7:0] d_in;
	logic [3:0] f5;
	logic f6_lo;
	logic f6_hi;
	logic f7;
	logic f8;
	logic [1:0] sum_of_products_or;
	logic [1:0] sop_mid;
	logic [1:0] bus_driver_logic;
	logic fn_ram;
	logic fn_shift;
	logic is_dp;
	logic [1:0] ram_k;
	logic [1:0] ram_wlog;
	logic [2:0] bank_mask;
	logic [2:0] bit_mask;
	logic [2:0] wr_bank;
	logic [2:0] dp_bank;

	////////////////////////////////////////////////////////////////
	// configuration load and slice control polarities

	assign cfg_load = init_pend | i_ginit;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			init_pend <= LCG_INIT_PEND_RST;
			clk_prev <= {4{LCG_CLK_PREV_RST}};
		end else begin
			init_pend <= 1'b0;
			clk_prev <= clk_level;
		end
	end

	assign clk_level = i_slice_clk ^ i_clk_inv;
	assign clk_edge = clk_level & ~clk_prev;
	assign ce_eff = ~i_ce_used | (i_slice_ce ^ i_ce_inv);
	assign setrst_eff = i_set_reset_input ^ i_set_reset_inv;
	assign opp_eff = i_opposite_force_input ^ i_opposite_force_inv;

	////////////////////////////////////////////////////////////////
	// ram organisation decode

	assign fn_ram = (i_func == LCG_FN_RAM);
	assign fn_shift = (i_func == LCG_FN_SHIFT);
	assign is_dp = (i_ram_org == LCG_DP16X4) | (i_ram_org == LCG_DP32X2) | (i_ram_org == LCG_DP64X1);
	assign ram_k = ((i_ram_org == LCG_SP32X4) | (i_ram_org == LCG_DP32X2)) ? 2'd1 :
		((i_ram_org == LCG_SP64X2) | (i_ram_org == LCG_DP64X1)) ? 2'd2 :
		(i_ram_org == LCG_SP128X1) ? 2'd3 : 2'd0;
	assign ram_wlog = is_dp ? 2'(2'd2 - ram_k) : 2'(2'd3 - ram_k);
	assign bank_mask = 3'(({1'b0, 3'b001} << ram_k) - 4'd1);
	assign bit_mask = 3'(({1'b0, 3'b001} << ram_wlog) - 4'd1);
	assign wr_bank = i_ram_addr[6:4] & bank_mask;
	assign dp_bank = {1'b0, i_dp_raddr[5:4]} & bank_mask;

	////////////////////////////////////////////////////////////////
	// look-up tables: logic, rom, ram or shift register

	genvar j;
	generate
		for (j = 0; j < LCG_LUTS; j++) begin : g_lut
			logic [2:0] loc;
			logic [2:0] lut_bank;
			logic [2:0] lut_bit;
			assign loc = is_dp ? {1'b0, 2'(j)} : 3'(j);
			assign lut_bank = loc >> ram_wlog;
			assign lut_bit = loc & bit_mask;
			// both halves of a dual-port ram write at the read/write port address
			assign ram_we[j] = fn_ram & clk_edge[j / 2] & setrst_eff[j / 2] & (lut_bank == wr_bank);
			assign ram_bit_in[j] = i_ram_din[lut_bit];
			assign shift_feed[j] = (j == 0) ? i_shift_in : lut_mem[(j == 0) ? 0 : j - 1][15];
			assign lut_out[j] = lut_mem[j][i_lut_addr[j]];

			always_ff @(posedge i_mclk or posedge i_rst) begin
				if (i_rst) begin
					lut_mem[j] <= LCG_LUT_RST;
				end else if (cfg_load) begin
					lut_mem[j] <= i_lut_init[j];
				end else if (ram_we[j]) begin
					lut_mem[j][i_ram_addr[3:0]] <= ram_bit_in[j];
				end else if (fn_shift & clk_edge[j / 2] & ce_eff[j / 2]) begin
					lut_mem[j] <= {lut_mem[j][14:0], shift_feed[j]};
				end
			end
		end
	endgenerate

	assign o_shift_out = lut_mem[LCG_LUTS - 1][15];

	////////////////////////////////////////////////////////////////
	// asynchronous ram read ports

	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_rd
			logic [2:0] idx_a;
			assign idx_a = 3'((wr_bank << ram_wlog) | 3'(b));
			assign o_ram_dout[b] = (3'(b) <= bit_mask) ? lut_mem[idx_a][i_ram_addr[3:0]] : 1'b0;
		end
		for (b = 0; b < 4; b++) begin : g_dp
			logic [2:0] idx_b;
			assign idx_b = 3'((dp_bank << ram_wlog) | 3'(b));
			assign o_dp_dout[b] = (is_dp & (3'(b) <= bit_mask))
				? lut_mem[3'(LCG_DP_BASE) | idx_b][i_dp_raddr[3:0]] : 1'b0;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// wide combiners

	genvar s;
	generate
		for (s = 0; s < LCG_SLICES; s++) begin : g_f5
			assign f5[s] = i_bypass_x_input[s] ? lut_out[2 * s + 1] : lut_out[2 * s];
		end
	endgenerate

	assign f6_lo = i_opposite_force_input[0] ? f5[1] : f5[0];
	assign f6_hi = i_opposite_force_input[2] ? f5[3] : f5[2];
	assign f7 = i_opposite_force_input[1] ? f6_hi : f6_lo;
	assign f8 = i_opposite_force_input[3] ? i_f8_neighbor : f7;
	assign o_five_input_combiner = f5;
	assign o_wide_combiner = {f8, f6_hi, f7, f6_lo};
	assign o_f7 = f7;

	////////////////////////////////////////////////////////////////
	// carry chains, adder and multiplier gates

	generate
		for (j = 0; j < LCG_LUTS; j++) begin : g_carry
			assign byp[j] = (j % 2 == 0) ? i_bypass_x_input[j / 2] : i_opposite_force_input[j / 2];
			assign multiplier_and_gate[j] = i_lut_addr[j][0] & i_lut_addr[j][1];
			assign carry_di[j] = i_di_sel[j] ? multiplier_and_gate[j] : byp[j];
			// two chains, slices 0-1 and 2-3, running upward
			assign carry_ci[j] = (j % 4 == 0) ? i_carry_in[j / 4] : carry_select_mux[(j % 4 == 0) ? 0 : j - 1];
			assign carry_select_mux[j] = lut_out[j] ? carry_ci[j] : carry_di[j];
			assign sum[j] = lut_out[j] ^ carry_ci[j];
			assign o_x[j] = i_xor_sel[j] ? sum[j] : lut_out[j];
			assign d_in[j] = i_lut_x_to_d[j] ? o_x[j] : byp[j];
		end
	endgenerate

	assign o_carry_out = {carry_select_mux[7], carry_select_mux[3]};

	////////////////////////////////////////////////////////////////
	// sum-of-products chain along each slice row

	generate
		for (s = 0; s < 2; s++) begin : g_sop
			assign sop_mid[s] = i_sop_in[s] | carry_select_mux[2 * s + 1];
			assign sum_of_products_or[s] = sop_mid[s] | carry_select_mux[2 * (s + 2) + 1];
		end
	endgenerate

	assign o_sop_out = sum_of_products_or;

	////////////////////////////////////////////////////////////////
	// internal bus drivers as and-or onto the horizontal lines

	assign bus_driver_logic = i_bus_in & i_bus_oe;
	assign o_hline_out = i_hline_in | bus_driver_logic;

	////////////////////////////////////////////////////////////////
	// storage elements, one pair per slice

	generate
		for (s = 0; s < LCG_SLICES; s++) begin : g_store
			lcg_store u_store (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.i_load(cfg_load),
				.i_clk_edge(clk_edge[s]),
				.i_clk_level(clk_level[s]),
				.i_ce(ce_eff[s]),
				.i_set_reset(setrst_eff[s]),
				.i_opposite_force(opp_eff[s]),
				.i_latch(i_latch_mode[s]),
				.i_mode(i_setrst_mode[s]),
				.i_force_one_attr(i_force_one_attr[2 * s +: 2]),
				.i_init_indep(i_init_indep[2 * s +: 2]),
				.i_power_up_one(i_power_up_one[2 * s +: 2]),
				.i_d(d_in[2 * s +: 2]),
				.o_q(o_q[2 * s +: 2])
			);
		end
	endgenerate
endmodule

// file: test/lcg_cell_group_chk.sv
// port assertions for the logic cell group
`timescale 1ns/1ns
module lcg_cell_group_chk import lcg_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_ginit,
	input wire lcg_func_t i_func,
	input wire lcg_ramorg_t i_ram_org,
	input wire logic [3:0] i_slice_clk,
	input wire logic [3:0] i_slice_ce,
	input wire logic [3:0] i_ce_used,
	input wire logic [3:0] i_clk_inv,
	input wire logic [3:0] i_ce_inv,
	input wire logic [3:0] i_set_reset_inv,
	input wire logic [3:0] i_opposite_force_inv,
	input wire logic [3:0] i_set_reset_input,
	input wire logic [3:0] i_bypass_x_input,
	input wire logic [3:0] i_opposite_force_input,
	input wire logic [3:0] i_latch_mode,
	input wire lcg_setrst_t [3:0] i_setrst_mode,
	input wire logic [7:0] i_force_one_attr,
	input wire logic [7:0] i_lut_x_to_d,
	input wire logic [6:0] i_ram_addr,
	input wire logic [7:0] i_ram_din,
	input wire logic [1:0] i_bus_in,
	input wire logic [1:0] i_bus_oe,
	input wire logic [1:0] i_hline_in,
	input wire logic [7:0] o_q,
	input wire logic [7:0] o_ram_dout,
	input wire logic [1:0] o_hline_out
);
	logic [3:0] prev;
	logic up;
	wire logic [3:0] cp = i_slice_clk ^ i_clk_inv;
	wire logic e0 = cp[0] & ~prev[0];
	wire logic ce0 = ~i_ce_used[0] | (i_slice_ce[0] ^ i_ce_inv[0]);
	wire logic sr0 = i_set_reset_input[0] ^ i_set_reset_inv[0];
	wire logic op0 = i_opposite_force_input[0] ^ i_opposite_force_inv[0];
	wire logic live = up & ~i_ginit;
	wire logic none0 = i_setrst_mode[0] == LCG_SETRST_NONE;
	wire logic [1:0] d0 = {i_opposite_force_input[0], i_bypass_x_input[0]};
	// the first edge after reset is the configuration load, so checks start one edge later
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			prev <= {4{LCG_CLK_PREV_RST}};
			up <= 1'b0;
		end else begin
			prev <= cp;
			up <= 1'b1;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_ff_capture: assert property (live && !i_latch_mode[0] && e0 && ce0 && none0 && !i_lut_x_to_d[1:0]
		|=> o_q[1:0] == $past(d0)) else $error("flip-flop did not capture");
	a_ce_hold: assert property (live && !i_latch_mode[0] && !ce0 && none0 |=> $stable(o_q[1:0]))
		else $error("flip-flop changed with enable off");
	a_latch_hold: assert property (live && i_latch_mode[0] && !cp[0] && none0 |=> $stable(o_q[1:0]))
		else $error("latch changed while closed");
	a_latch_pass: assert property (live && i_latch_mode[0] && cp[0] && ce0 && none0 && !i_lut_x_to_d[1:0]
		|=> o_q[1:0] == $past(d0)) else $error("latch did not pass input");
	a_sync_rst_wins: assert property (live && i_setrst_mode[0] == LCG_SYNC_BOTH && e0 && sr0 && op0
		|=> o_q[1:0] == 2'b00) else $error("sync reset lost to set");
	a_async_clr_now: assert property (live && i_setrst_mode[0] inside {LCG_ASYNC_CLR, LCG_ASYNC_BOTH}
		&& sr0 && !i_force_one_attr[1] |-> !o_q[1]) else $error("async clear not seen");
	a_async_pre_now: assert property (live && i_setrst_mode[0] == LCG_ASYNC_PRE && sr0 && i_force_one_attr[0]
		|-> o_q[0]) else $error("async preset not seen");
	a_hline_andor: assert property (o_hline_out == (i_hline_in | (i_bus_in & i_bus_oe)))
		else $error("bus line wrong");
	a_ram_write: assert property (live && i_func == LCG_FN_RAM && i_ram_org == LCG_SP16X8 && e0 && sr0
		&& i_ram_addr[6:4] == 3'h0 |=> $stable(i_ram_addr) -> o_ram_dout[1:0] == $past(i_ram_din[1:0]))
		else $error("ram write not read back");
endmodule
bind lcg_cell_group lcg_cell_group_chk u_chk (.*);

// file: test/lcg_fabric_model.sv
// fabric model: turns a tick request into one high cycle of each requested slice clock
`timescale 1ns/1ns
module lcg_fabric_model (
	input wire logic i_mclk,
	input wire logic [3:0] i_req,
	output logic [3:0] o_slice_clk
);
	initial o_slice_clk = 4'h0;
	// clock returns low after one cycle so every request is a clean shared edge
	always @(negedge i_mclk) begin
		o_slice_clk <= (o_slice_clk != 4'h0) ? 4'h0 : i_req;
	end
endmodule

// file: test/lcg_cell_group_tb_top.sv
// self-checking bench for the logic cell group
`timescale 1ns/1ns
module lcg_cell_group_tb_top import lcg_pkg::*;;
	logic i_mclk, i_rst, i_ginit, i_shift_in, i_f8_neighbor, o_f7, o_shift_out;
	lcg_func_t i_func;
	lcg_ramorg_t i_ram_org;
	lcg_setrst_t md;
	lcg_setrst_t [3:0] i_setrst_mode;
	logic [7:0][15:0] i_lut_init;
	logic [7:0][3:0] i_lut_addr;
	logic [3:0] i_slice_ce, i_ce_used, i_clk_inv, i_ce_inv, i_set_reset_inv, i_opposite_force_inv, req;
	logic [3:0] i_set_reset_input, i_bypass_x_input, i_opposite_force_input, i_latch_mode;
	logic [3:0] o_five_input_combiner, o_wide_combiner, o_dp_dout;
	logic [7:0] i_force_one_attr, i_init_indep, i_power_up_one, i_lut_x_to_d, i_xor_sel, i_di_sel;
	logic [7:0] i_ram_din, o_x, o_q, o_ram_dout, mem[16];
	logic [6:0] i_ram_addr;
	logic [5:0] i_dp_raddr;
	logic [1:0] i_carry_in, i_sop_in, i_bus_in, i_bus_oe, i_hline_in, o_carry_out, o_sop_out, o_hline_out;
	wire logic [3:0] i_slice_clk;
	logic [31:0] seed, r;
	logic [15:0] t0;
	bit q[8];
	int errors, checks_done;
	lcg_cell_group uut (.*);
	lcg_fabric_model u_fab (.i_mclk(i_mclk), .i_req(req), .o_slice_clk(i_slice_clk));
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [7:0] qv();
		for (int k = 0; k < 8; k++) qv[k] = q[k];
	endfunction
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one slice clock pulse through the fabric, then let the result land
	task automatic tick(logic [3:0] m);
		req <= m;
		@(negedge i_mclk);
		req <= 4'h0;
		repeat (2) @(negedge i_mclk);
	endtask
	// expected storage after a pulse on the slices in m
	task automatic model(logic [3:0] m);
		int e;
		bit sr, op, st, rs;
		for (int k = 0; k < 8; k++) begin
			e = k / 2;
			sr = i_set_reset_input[e] ^ i_set_reset_inv[e];
			op = i_opposite_force_input[e] ^ i_opposite_force_inv[e];
			st = (i_force_one_attr[k] ? sr : op) && i_setrst_mode[e] inside {LCG_SYNC_SET, LCG_SYNC_BOTH, LCG_ASYNC_PRE, LCG_ASYNC_BOTH};
			rs = (i_force_one_attr[k] ? op : sr) && i_setrst_mode[e] inside {LCG_SYNC_RST, LCG_SYNC_BOTH, LCG_ASYNC_CLR, LCG_ASYNC_BOTH};
			if (m[e] && rs) q[k] = 1'b0;
			else if (m[e] && st) q[k] = 1'b1;
			else if (m[e] && (!i_ce_used[e] || (i_slice_ce[e] ^ i_ce_inv[e])))
				q[k] = (k % 2) ? i_opposite_force_input[e] : i_bypass_x_input[e];
		end
	endtask
	// expected combiner, carry, sum and or-chain outputs from the loaded tables
	task automatic comb_chk();
		logic [7:0] lo, cy, x;
		logic [3:0] f5;
		logic c, f6l, f6h, f7, f8;
		for (int j = 0; j < 8; j++) begin
			lo[j] = i_lut_init[j][i_lut_addr[j]];
			c = (j % 4 == 0) ? i_carry_in[j / 4] : cy[(j % 4 == 0) ? 0 : j - 1];
			cy[j] = lo[j] ? c : (i_di_sel[j] ? (i_lut_addr[j][0] & i_lut_addr[j][1])
				: ((j % 2) ? i_opposite_force_input[j / 2] : i_bypass_x_input[j / 2]));
			x[j] = i_xor_sel[j] ? (lo[j] ^ c) : lo[j];
		end
		for (int s = 0; s < 4; s++) f5[s] = i_bypass_x_input[s] ? lo[2 * s + 1] : lo[2 * s];
		f6l = i_opposite_force_input[0] ? f5[1] : f5[0];
		f6h = i_opposite_force_input[2] ? f5[3] : f5[2];
		f7 = i_opposite_force_input[1] ? f6h : f6l;
		f8 = i_opposite_force_input[3] ? i_f8_neighbor : f7;
		chk("x", x, o_x);
		chk("combiner", {f8, f6h, f7, f6l, f5}, {o_wide_combiner, o_five_input_combiner});
		chk("f7", {7'h0, f7}, {7'h0, o_f7});
		chk("carry", {2'h0, i_sop_in | {cy[3], cy[1]} | {cy[7], cy[5]}, 2'h0, cy[7], cy[3]},
			{2'h0, o_sop_out, 2'h0, o_carry_out});
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge i_mclk);
		errors++;
		report_and_stop();
	end
	initial begin
		seed = 32'he7b8;
		{errors, checks_done, req, i_ginit, i_shift_in, i_f8_neighbor, i_lut_addr, i_slice_ce} = '0;
		{i_clk_inv, i_ce_inv, i_set_reset_inv, i_opposite_force_inv, i_set_reset_input} = '0;
		{i_bypass_x_input, i_opposite_force_input, i_latch_mode, i_lut_x_to_d, i_xor_sel} = '0;
		{i_di_sel, i_ram_din, i_ram_addr, i_dp_raddr, i_carry_in, i_sop_in, i_bus_in, i_bus_oe, i_hline_in} = '0;
		i_rst = 1'b1;
		i_ce_used = 4'hf;
		i_func = LCG_FN_LOGIC;
		i_ram_org = LCG_SP16X8;
		i_setrst_mode = {4{LCG_SETRST_NONE}};
		i_lut_init = {rnd(), rnd(), rnd(), rnd()};
		i_force_one_attr = 8'hf1;
		i_init_indep = 8'h0e;
		i_power_up_one = 8'h04;
		repeat (8) @(negedge i_mclk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_mclk);
		chk("power_up", 8'hf5, o_q);
		i_force_one_attr = 8'h0d;
		i_init_indep = 8'hf0;
		i_power_up_one = 8'h30;
		i_ginit = 1'b1;
		@(negedge i_mclk);
		i_ginit = 1'b0;
		@(negedge i_mclk);
		chk("ginit", 8'h3d, o_q);
		for (int k = 0; k < 8; k++) q[k] = 1'(8'h3d >> k);
		$display("test power_up done");
		repeat (40) begin
			r = rnd();
			{i_bypass_x_input, i_opposite_force_input, i_slice_ce, i_ce_used, i_ce_inv, i_latch_mode, i_set_reset_input} = r[27:0];
			model(r[31:28]);
			tick(r[31:28]);
			chk("store", qv(), o_q);
		end
		$display("test storage done");
		md = md.first();
		repeat (7) begin
			i_setrst_mode[0] = md;
			for (int c = 1; c < 4; c++) begin
				r = rnd();
				{i_bypass_x_input[0], i_ce_inv[0], i_slice_ce[0], i_ce_used[0]} = r[5:2];
				{i_opposite_force_inv[0], i_set_reset_inv[0]} = r[1:0];
				{i_opposite_force_input[0], i_set_reset_input[0]} = c[1:0] ^ r[1:0];
				model(4'h1);
				tick(4'h1);
				chk("setrst", qv(), o_q);
			end
			md = md.next();
		end
		i_setrst_mode[0] = LCG_SETRST_NONE;
		$display("test set_reset done");
		i_func = LCG_FN_RAM;
		{i_ce_used, i_set_reset_inv} = '0;
		for (int dp = 0; dp < 2; dp++) begin
			i_ram_org = dp ? LCG_DP16X4 : LCG_SP16X8;
			i_set_reset_input = 4'hf;
			for (int a = 0; a < 16; a++) begin
				r = rnd();
				mem[a] = dp ? {4'h0, r[3:0]} : r[7:0];
				t0[a] = r[0];
				i_ram_addr = 7'(a);
				i_ram_din = r[7:0];
				tick(4'hf);
			end
			i_set_reset_input = 4'h0;
			i_ram_addr = 7'h0;
			i_ram_din = ~mem[0];
			tick(4'hf);
			for (int a = 0; a < 16; a++) begin
				i_ram_addr = 7'(15 - a);
				i_dp_raddr = 6'(a);
				#5;
				chk("ram", mem[15 - a], o_ram_dout);
				if (dp) chk("dp", mem[a], {4'h0, o_dp_dout});
				@(negedge i_mclk);
			end
		end
		$display("test ram done");
		i_func = LCG_FN_SHIFT;
		i_ce_used[0] = 1'b1;
		repeat (20) begin
			r = rnd();
			{i_shift_in, i_slice_ce[0]} = r[1:0];
			if (r[0] ^ i_ce_inv[0]) t0 = {t0[14:0], r[1]};
			tick(4'h1);
		end
		for (int a = 0; a < 16; a++) begin
			i_lut_addr[0] = 4'(a);
			#5;
			chk("tap", {7'h0, t0[a]}, {7'h0, o_x[0]});
			@(negedge i_mclk);
		end
		$display("test shift done");
		i_func = LCG_FN_LOGIC;
		i_ginit = 1'b1;
		@(negedge i_mclk);
		i_ginit = 1'b0;
		@(negedge i_mclk);
		chk("shift_out", {7'h0, i_lut_init[7][15]}, {7'h0, o_shift_out});
		repeat (20) begin
			r = rnd();
			{i_bus_in, i_bus_oe, i_hline_in, i_carry_in, i_sop_in, i_f8_neighbor, i_dp_raddr, i_xor_sel, i_di_sel} = {r[0], r};
			i_lut_addr = rnd();
			{i_bypass_x_input, i_opposite_force_input} = 8'(rnd());
			#5;
			chk("hline", {6'h0, i_hline_in | (i_bus_in & i_bus_oe)}, {6'h0, o_hline_out});
			comb_chk();
			@(negedge i_mclk);
		end
		$display("test bus done");
		report_and_stop();
	end
endmodule
